/* src/mor_cfg.svh */
// Constants for the multiply-accumulate overflow and result readout block.
// Notes on behaviour
// - Signed MAC overflows when non-negative addends give a negative sum.
// - Signed MAC overflows when negative addends give a non-negative sum.
// - Accumulated result is kept while the overflow flag is clear.
// - A compute-load MAC that does not overflow clears the overflow flag.
// - Compute-load outside read and MAC modes, or feed-load outside read mode, clears the overflow flag.
// - MAC returns one selected 16-bit half plus condition flags.
// - Accumulated result stays unchanged until a later operation rewrites it.
// - Read mode 0x03 returns bits 15:0, 0x13 bits 31:16, flags zero.
// - Compute-load in read mode never modifies the accumulated result.
// - Signed MAC multiplies two 16-bit operands and adds to 32-bit result.
// - During MAC only overflow may be one; carry, zero, negative stay zero.
// - Mode value low nibble is the operation; bit 4 selects upper half.
`ifndef MOR_CFG_SVH
`define MOR_CFG_SVH

`define MOR_OP_CLEAR   4'h0
`define MOR_OP_LOAD16  4'h1
`define MOR_OP_LOAD32  4'h2
`define MOR_OP_READ    4'h3
`define MOR_OP_SMAC    4'h7
`define MOR_HALF_BIT   4
`define MOR_FLAGS_NONE 4'h0
`define MOR_FLAGS_OVF  4'h4
`define MOR_FLAGS_CZN  4'hb
`define MOR_MODE_RST   5'h00
`define MOR_ACC_RST    32'h0000_0000
`define MOR_SIGN_BIT   31

`endif

/* src/mor_pkg.sv */
// Types shared by the multiply-accumulate readout block.
package mor_pkg;

    typedef enum logic [1:0]
    {
        MOR_NONE,
        MOR_COPROC_MODE_WRITE,
        MOR_COPROC_COMPUTE_LOAD,
        MOR_COPROC_FEED_LOAD
    } mor_instr_t;

    typedef struct packed
    {
        logic        valid;
        mor_instr_t  instr;
        logic [15:0] opRd;
        logic [15:0] opRs;
    } mor_req_t;

    typedef struct packed
    {
        logic        valid;
        logic [15:0] data;
        logic [3:0]  conditionFlags;
    } mor_resp_t;

endpackage : mor_pkg

/* src/mor_mac_unit.sv */
// Signed multiply-accumulate datapath with overflow detection.
`timescale 1ns/1ps
`include "mor_cfg.svh"

module mor_mac_unit
(
    input  wire logic [15:0] multA,
    input  wire logic [15:0] multB,
    input  wire logic [31:0] accIn,
    output logic      [31:0] product,
    output logic      [31:0] sum,
    output logic             overflow
);

    logic signed [31:0] extA;
    logic signed [31:0] extB;
    logic               signP;
    logic               signA;
    logic               signS;

    assign extA    = $signed({{16{multA[15]}}, multA});
    assign extB    = $signed({{16{multB[15]}}, multB});
    assign product = 32'(extA * extB);
    assign sum     = 32'(product + accIn);

    assign signP = product[`MOR_SIGN_BIT];
    assign signA = accIn[`MOR_SIGN_BIT];
    assign signS = sum[`MOR_SIGN_BIT];

    // Same-sign addends whose sum flips sign have wrapped.
    assign overflow = (!signP && !signA && signS)
                    || (signP && signA && !signS);

endmodule : mor_mac_unit

/* src/mor_mac_readout.sv */
// Coprocessor result register, overflow flag and result readout.
`timescale 1ns/1ps
`include "mor_cfg.svh"

module mor_mac_readout
(
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire mor_pkg::mor_req_t   req,
    output mor_pkg::mor_resp_t       resp,
    output logic      [31:0]         accValue,
    output logic                     overflowFlag,
    output logic      [4:0]          modeValue
);

    logic [4:0]         mode_q;
    logic [31:0]        acc_q;
    logic               ovf_q;
    mor_pkg::mor_resp_t resp_q;

    logic [3:0]  modeOp;
    logic        halfSel;
    logic        isModeWr;
    logic        isCompute;
    logic        isFeed;
    logic        isMac;
    logic [31:0] macProduct;
    logic [31:0] macSum;
    logic        macOvf;

    assign modeOp    = mode_q[3:0];
    assign halfSel   = mode_q[`MOR_HALF_BIT];
    assign isModeWr  = req.valid
                     && req.instr == mor_pkg::MOR_COPROC_MODE_WRITE;
    assign isCompute = req.valid
                     && req.instr == mor_pkg::MOR_COPROC_COMPUTE_LOAD;
    assign isFeed    = req.valid
                     && req.instr == mor_pkg::MOR_COPROC_FEED_LOAD;
    assign isMac     = isCompute && modeOp == `MOR_OP_SMAC;

    mor_mac_unit u_mac
    (
        .multA    (req.opRd),
        .multB    (req.opRs),
        .accIn    (acc_q),
        .product  (macProduct),
        .sum      (macSum),
        .overflow (macOvf)
    );

    // The mode value arrives on the source operand of a mode write.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            mode_q <= `MOR_MODE_RST;
        else if (isModeWr)
            mode_q <= req.opRs[4:0];
    end

    // Writing the clear mode zeroes the result register at once.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            acc_q <= `MOR_ACC_RST;
        else if (isModeWr && req.opRs[3:0] == `MOR_OP_CLEAR)
            acc_q <= `MOR_ACC_RST;
        else if (isFeed && modeOp == `MOR_OP_LOAD16)
            acc_q <= {16'h0000, req.opRs};
        else if (isFeed && modeOp == `MOR_OP_LOAD32)
            acc_q <= {req.opRd, req.opRs};
        else if (isMac)
            acc_q <= macSum;
        // Any other case keeps the value, read mode included.
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            ovf_q <= 1'b0;
        else if (isMac)
            ovf_q <= macOvf;
        else if ((isCompute || isFeed) && modeOp != `MOR_OP_READ)
            ovf_q <= 1'b0;
    end

    // Only one half leaves per compute-load; flags carry overflow alone.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            resp_q <= '0;
        end
        else
        begin
            resp_q.valid <= isCompute;
            if (isMac)
            begin
                resp_q.data <= halfSel ? macSum[31:16] : macSum[15:0];
                resp_q.conditionFlags <= macOvf ? `MOR_FLAGS_OVF
                                                : `MOR_FLAGS_NONE;
            end
            else if (isCompute)
            begin
                resp_q.data <= halfSel ? acc_q[31:16] : acc_q[15:0];
                resp_q.conditionFlags <= `MOR_FLAGS_NONE;
            end
        end
    end

    assign resp         = resp_q;
    assign accValue     = acc_q;
    assign overflowFlag = ovf_q;
    assign modeValue    = mode_q;

    // Independent reference for the accumulate path.
    logic signed [31:0] refA;
    logic signed [31:0] refB;
    logic        [31:0] refSum;

    assign refA   = $signed({{16{req.opRd[15]}}, req.opRd});
    assign refB   = $signed({{16{req.opRs[15]}}, req.opRs});
    assign refSum = 32'(acc_q + 32'(refA * refB));

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence seqMacPosPos;
        isMac && !macProduct[31] && !acc_q[31] && macSum[31];
    endsequence

    sequence seqMacNegNeg;
        isMac && macProduct[31] && acc_q[31] && !macSum[31];
    endsequence

    sequence seqMacClean;
        isMac && !macOvf;
    endsequence

    sequence seqQuiet2;
        !req.valid [*2];
    endsequence

    chk_ovf_pos_pos: assert property (seqMacPosPos |=> overflowFlag
        && resp.conditionFlags == `MOR_FLAGS_OVF)
        else $error("overflow not flagged for positive addends");

    chk_ovf_neg_neg: assert property (seqMacNegNeg |=> overflowFlag
        && resp.conditionFlags == `MOR_FLAGS_OVF)
        else $error("overflow not flagged for negative addends");

    chk_mac_clean_clear: assert property (seqMacClean |=> !overflowFlag
        && resp.conditionFlags == `MOR_FLAGS_NONE)
        else $error("overflow flag left set after clean mac");

    chk_other_mode_clear: assert property (
        (isCompute || isFeed) && modeOp != `MOR_OP_READ
        && modeOp != `MOR_OP_SMAC |=> !overflowFlag)
        else $error("overflow flag not cleared outside read mode");

    chk_read_flag_kept: assert property (
        isCompute && modeOp == `MOR_OP_READ |=> $stable(overflowFlag))
        else $error("read mode disturbed overflow flag");

    chk_mac_accum: assert property (
        isMac |=> accValue == $past(refSum))
        else $error("accumulated result wrong after mac");

    chk_mac_flags_czn: assert property (isMac |=> resp.valid
        && (resp.conditionFlags & `MOR_FLAGS_CZN) == `MOR_FLAGS_NONE)
        else $error("carry, zero or negative set by mac");

    chk_mac_half_out: assert property (isMac |=> resp.data ==
        (modeValue[`MOR_HALF_BIT] ? accValue[31:16] : accValue[15:0]))
        else $error("mac returned wrong result half");

    chk_read_low_half: assert property (
        isCompute && mode_q == 5'h03 |=> resp.valid
        && resp.data == accValue[15:0]
        && resp.conditionFlags == `MOR_FLAGS_NONE)
        else $error("read mode low half wrong");

    chk_read_high_half: assert property (
        isCompute && mode_q == 5'h13 |=> resp.valid
        && resp.data == accValue[31:16]
        && resp.conditionFlags == `MOR_FLAGS_NONE)
        else $error("read mode high half wrong");

    chk_read_no_write: assert property (
        isCompute && modeOp == `MOR_OP_READ |=> $stable(accValue))
        else $error("read mode modified result register");

    chk_clean_retained: assert property (seqMacClean ##1 seqQuiet2
        |-> $stable(accValue) && !overflowFlag)
        else $error("clean mac result not retained");

    chk_idle_hold: assert property (!req.valid |=> $stable(accValue))
        else $error("result register changed without an operation");

    // A mode write takes its value from the low source bits.
    chk_mode_taken: assert property (
        isModeWr |=> modeValue == 5'($past(req.opRs)))
        else $error("mode value not taken from mode write");

    // A feed-load in read mode leaves both flag and result alone.
    chk_read_feed_kept: assert property (
        isFeed && modeOp == `MOR_OP_READ
        |=> $stable(overflowFlag) && $stable(accValue))
        else $error("feed-load in read mode changed state");

    chk_resp_pulse: assert property (!isCompute |=> !resp.valid)
        else $error("answer strobe without a compute-load");

    chk_load_low: assert property (
        isFeed && modeOp == `MOR_OP_LOAD16
        |=> accValue[31:16] == 16'h0000
        && accValue[15:0] == $past(req.opRs))
        else $error("short load wrote wrong result value");

    chk_load_full: assert property (
        isFeed && modeOp == `MOR_OP_LOAD32
        |=> accValue == {$past(req.opRd), $past(req.opRs)})
        else $error("full load wrote wrong result value");

    chk_mode_clear: assert property (
        isModeWr && req.opRs[3:0] == `MOR_OP_CLEAR
        |=> accValue == `MOR_ACC_RST)
        else $error("clear mode left result register set");

endmodule : mor_mac_readout

/* tb/mor_core_model.sv */
// Processor core model that issues coprocessor instructions.
`timescale 1ns/1ps

module mor_core_model
(
    input  wire logic         sys_clk,
    output mor_pkg::mor_req_t req
);

    initial req = '0;

    task automatic issue(input mor_pkg::mor_instr_t ins,
                         input logic [15:0] rd, input logic [15:0] rs);
        @(negedge sys_clk);
        req = '{1'b1, ins, rd, rs};
    endtask : issue

    // Released operands toggle so that stale values are never relied on.
    task automatic idle();
        @(negedge sys_clk);
        req.valid = 1'b0;
        req.opRd  = ~req.opRd;
        req.opRs  = ~req.opRs;
    endtask : idle

    // The other half is fetched by a read mode write and a compute-load.
    task automatic readHalf(input logic hi);
        issue(mor_pkg::MOR_COPROC_MODE_WRITE, 16'h0000,
              {11'h000, ~hi, 4'h3});
        issue(mor_pkg::MOR_COPROC_COMPUTE_LOAD, 16'h0000, 16'h0000);
    endtask : readHalf

endmodule : mor_core_model

/* tb/mor_mac_readout_tb_top.sv */
// Testbench for the multiply-accumulate readout block.
`timescale 1ns/1ps

module mor_mac_readout_tb_top;
    logic               sys_clk = 1'b0;
    logic               rst_b;
    mor_pkg::mor_req_t  req;
    mor_pkg::mor_resp_t resp;
    logic [31:0]        accValue;
    logic               overflowFlag;
    logic [4:0]         modeValue;
    int                 n_fail;
    int                 compares;

    mor_core_model uCore (.sys_clk(sys_clk), .req(req));
    mor_mac_readout uut (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
        .resp(resp), .accValue(accValue), .overflowFlag(overflowFlag),
        .modeValue(modeValue));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic setMode(input logic [4:0] m);
        uCore.issue(mor_pkg::MOR_COPROC_MODE_WRITE, 16'h0000, {11'h000, m});
    endtask : setMode

    task automatic feed(input logic [31:0] v);
        uCore.issue(mor_pkg::MOR_COPROC_FEED_LOAD, v[31:16], v[15:0]);
    endtask : feed

    // Checks the answer that follows the compute-load just issued.
    task automatic answer(input logic [15:0] d, input logic [3:0] f);
        uCore.idle();
        cmp(32'(resp.valid), 32'h1);
        cmp(32'(resp.data), 32'(d));
        cmp(32'(resp.conditionFlags), 32'(f));
    endtask : answer

    task automatic macCase(input logic [31:0] init, input logic [15:0] a,
                           input logic [15:0] b, input logic hi);
        logic [31:0] p;
        logic [31:0] s;
        logic        ovf;
        p   = {{16{a[15]}}, a} * {{16{b[15]}}, b};
        s   = init + p;
        ovf = (p[31] == init[31]) && (s[31] != p[31]);
        setMode(5'h02);
        feed(init);
        setMode({hi, 4'h7});
        uCore.idle();
        cmp(32'(overflowFlag), 32'h0);
        cmp(32'(modeValue), 32'({hi, 4'h7}));
        uCore.issue(mor_pkg::MOR_COPROC_COMPUTE_LOAD, a, b);
        answer(hi ? s[31:16] : s[15:0], ovf ? 4'h4 : 4'h0);
        cmp(accValue, s);
        cmp(32'(overflowFlag), 32'(ovf));
        uCore.readHalf(hi);
        answer(hi ? s[15:0] : s[31:16], 4'h0);
        cmp(accValue, s);
        cmp(32'(overflowFlag), 32'(ovf));
    endtask : macCase

    task automatic clearByMac();
        setMode(5'h02);
        feed(32'h7fff_ffff);
        setMode(5'h07);
        uCore.issue(mor_pkg::MOR_COPROC_COMPUTE_LOAD, 16'h0001, 16'h0001);
        answer(16'h0000, 4'h4);
        uCore.issue(mor_pkg::MOR_COPROC_COMPUTE_LOAD, 16'h0000, 16'h0000);
        answer(16'h0000, 4'h0);
        uCore.idle();
        cmp(32'(overflowFlag), 32'h0);
        cmp(accValue, 32'h8000_0000);
        setMode(5'h00);
        uCore.idle();
        cmp(accValue, 32'h0000_0000);
    endtask : clearByMac

    // Short load, feed-load ignored in read mode, flag cleared elsewhere.
    task automatic otherModes();
        setMode(5'h01);
        feed(32'hffff_1234);
        setMode(5'h07);
        uCore.idle();
        cmp(accValue, 32'h0000_1234);
        uCore.issue(mor_pkg::MOR_COPROC_COMPUTE_LOAD, 16'h8000, 16'h8000);
        answer(16'h1234, 4'h0);
        uCore.issue(mor_pkg::MOR_COPROC_COMPUTE_LOAD, 16'h8000, 16'h8000);
        answer(16'h1234, 4'h4);
        setMode(5'h03);
        feed(32'h0000_0000);
        uCore.idle();
        cmp(accValue, 32'h8000_1234);
        cmp(32'(overflowFlag), 32'h1);
        setMode(5'h01);
        uCore.issue(mor_pkg::MOR_COPROC_COMPUTE_LOAD, 16'h0000, 16'h0000);
        answer(16'h1234, 4'h0);
        cmp(32'(overflowFlag), 32'h0);
        cmp(accValue, 32'h8000_1234);
    endtask : otherModes

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        n_fail   = 0;
        compares = 0;
        rst_b    = 1'b0;
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        cmp(accValue, 32'h0);
        cmp(32'({overflowFlag, modeValue, resp.valid}), 32'h0);
        macCase(32'h0000_0005, 16'h0003, 16'hfffe, 1'b0);
        macCase(32'h7fff_ffff, 16'h0001, 16'h0001, 1'b1);
        macCase(32'h8000_0000, 16'h0001, 16'hffff, 1'b0);
        macCase(32'h7fff_ffff, 16'hffff, 16'h0001, 1'b1);
        macCase(32'hffff_fff0, 16'h8000, 16'h8000, 1'b0);
        clearByMac();
        otherModes();
        give_verdict();
    end

    initial
    begin
        #20000;
        n_fail++;
        give_verdict();
    end

endmodule : mor_mac_readout_tb_top
